//--- ivd_params.svh
`ifndef IVD_PARAMS_SVH
`define IVD_PARAMS_SVH
`define IVD_VEC_DIVIDE 8'h00
`define IVD_VEC_NMI 8'h02
`define IVD_VEC_INVALID_OP 8'h06
`define IVD_VEC_NO_DEVICE 8'h07
`define IVD_VEC_DOUBLE 8'h08
`define IVD_VEC_MACHINE 8'h12
`define IVD_ARCH_LAST 8'h1F
`define IVD_USER_FIRST 8'h20
`define IVD_LOCAL_FIRST 8'h10
`define IVD_DESC_SHIFT 3
`endif

//--- ivd_pkg.sv
`default_nettype none
package ivd_pkg;
  typedef logic [7:0] ivd_vec_t;
  typedef enum logic [1:0] {IVD_FAULT, IVD_TRAP, IVD_ABORT, IVD_MASKABLE_REQUEST_INPUT} ivd_class_e;
  typedef enum {IVD_IDLE, IVD_ACK, IVD_RUN} ivd_state_e;
endpackage
`default_nettype wire

//--- ivd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ivd_pin_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // ivd_pin_sync
`default_nettype wire

//--- ivd_dispatch.sv
`timescale 1ns/1ps
`include "ivd_params.svh"
`default_nettype none
module ivd_dispatch
  import ivd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] localInterruptPins,
  input wire logic localUnitEnable,
  input wire logic [7:0] localVectorTable0,
  input wire logic [7:0] localVectorTable1,
  input wire logic interruptEnable,
  input wire logic busVectorValid,
  input wire logic [7:0] busVector,
  input wire logic swIntReq,
  input wire logic [7:0] swIntVector,
  input wire logic divideError,
  input wire logic invalidOpcode,
  input wire logic deviceNotAvailable,
  input wire logic doubleFaultReq,
  input wire logic hwError,
  input wire logic busError,
  input wire logic handlerDone,
  input wire logic [31:0] descBase,
  output logic vectorReadReq,
  output logic dispatchValid,
  output logic [7:0] dispatchVector,
  output logic [31:0] descAddress,
  output logic [1:0] eventClass,
  output logic errorCodePush,
  output logic [31:0] errorCode,
  output logic taskSuspended,
  output logic resumeTask,
  output logic illegalVector
);
  // ----------------------------------------
  // pin capture
  // ----------------------------------------
  logic pin0;
  logic pin1;
  logic pin1Prev;
  logic nmiPending;
  ivd_state_e state;
  ivd_state_e next_state;
  ivd_pin_sync sync0 (.clock(clock), .rst_n(rst_n), .pinIn(localInterruptPins[0]), .level(pin0));
  ivd_pin_sync sync1 (.clock(clock), .rst_n(rst_n), .pinIn(localInterruptPins[1]), .level(pin1));

  function automatic logic [31:0] descAddr(input logic [31:0] base, input ivd_vec_t v);
    descAddr = base + {21'h0, v, 3'h0};
  endfunction

  // ----------------------------------------
  // request selection
  // ----------------------------------------
  // nmi is an edge, held pending so a busy handler cannot drop it
  wire nmiEdge = !localUnitEnable && pin1 && !pin1Prev;
  wire maskReq = !localUnitEnable && pin0 && interruptEnable;
  wire locReq0 = localUnitEnable && pin0 && interruptEnable;
  wire locReq1 = localUnitEnable && pin1 && interruptEnable;
  wire [7:0] locVec = locReq0 ? localVectorTable0 : localVectorTable1;
  wire locBad = (locReq0 || locReq1) && (locVec < `IVD_LOCAL_FIRST);
  wire machineCheck = hwError || busError;
  wire idle = (state == IVD_IDLE);
  // priority: double fault, machine check, other exceptions, nmi, software, local, maskable
  wire excReq = doubleFaultReq || divideError || invalidOpcode || deviceNotAvailable || machineCheck;
  wire [7:0] excVec = doubleFaultReq ? `IVD_VEC_DOUBLE :
                      machineCheck ? `IVD_VEC_MACHINE :
                      divideError ? `IVD_VEC_DIVIDE :
                      invalidOpcode ? `IVD_VEC_INVALID_OP :
                      `IVD_VEC_NO_DEVICE;
  wire [1:0] excClass = (doubleFaultReq || machineCheck) ? 2'(IVD_ABORT) : 2'(IVD_FAULT);
  // an edge not yet latched still holds lower requests back, else a maskable one slips ahead
  wire nmiReq = nmiPending || nmiEdge;
  wire nmiGo = idle && !excReq && nmiPending;
  wire swGo = idle && !excReq && !nmiReq && swIntReq;
  wire locGo = idle && !excReq && !nmiReq && !swIntReq && (locReq0 || locReq1) && !locBad;
  wire maskGo = idle && !excReq && !nmiReq && !swIntReq && maskReq && !vectorReadReq;
  wire immGo = idle && (excReq || nmiGo || swGo || locGo);
  wire [7:0] immVec = excReq ? excVec : nmiGo ? `IVD_VEC_NMI : swGo ? swIntVector : locVec;
  wire [1:0] immClass = excReq ? excClass : 2'(IVD_MASKABLE_REQUEST_INPUT);
  wire busGo = (state == IVD_ACK) && busVectorValid;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      IVD_IDLE: begin
        if (immGo) begin
          next_state = IVD_RUN;
        end else if (maskGo) begin
          next_state = IVD_ACK;
        end
      end
      IVD_ACK: begin
        if (busGo) begin
          next_state = IVD_RUN;
        end
      end
      IVD_RUN: begin
        if (handlerDone) begin
          next_state = IVD_IDLE;
        end
      end
      default: next_state = IVD_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= IVD_IDLE;
      pin1Prev <= 1'b0;
      nmiPending <= 1'b0;
      vectorReadReq <= 1'b0;
      dispatchValid <= 1'b0;
      dispatchVector <= 8'h00;
      descAddress <= 32'h0000_0000;
      eventClass <= 2'h0;
      errorCodePush <= 1'b0;
      errorCode <= 32'h0000_0000;
      taskSuspended <= 1'b0;
      resumeTask <= 1'b0;
      illegalVector <= 1'b0;
    end else begin
      state <= next_state;
      pin1Prev <= pin1;
      // a new edge in the serving cycle wins over the clear
      nmiPending <= nmiEdge || (nmiPending && !nmiGo);
      vectorReadReq <= (maskGo && !immGo) || (vectorReadReq && !busGo);
      dispatchValid <= immGo || busGo;
      illegalVector <= idle && locBad;
      resumeTask <= (state == IVD_RUN) && handlerDone && (eventClass != 2'(IVD_ABORT));
      if (immGo || busGo) begin
        dispatchVector <= busGo ? busVector : immVec;
        descAddress <= descAddr(descBase, busGo ? busVector : immVec);
        eventClass <= busGo ? 2'(IVD_MASKABLE_REQUEST_INPUT) : immClass;
        errorCodePush <= !busGo && excReq && doubleFaultReq;
        errorCode <= 32'h0000_0000;
        taskSuspended <= 1'b1;
      end else if (state == IVD_RUN && handlerDone) begin
        taskSuspended <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  nmi_vector_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    nmiGo |=>
    dispatchValid && dispatchVector == 8'h02)
    else $error("nmi not on vector 2");
  nmi_first_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    nmiReq && maskReq && idle && !excReq |=>
    !vectorReadReq)
    else $error("maskable served before nmi");
  bus_vector_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busGo |=>
    dispatchVector == $past(busVector) && !vectorReadReq)
    else $error("bus vector not taken");
  desc_index_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    dispatchValid |->
    descAddress == descAddr($past(descBase), dispatchVector))
    else $error("descriptor address wrong");
  double_code_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && doubleFaultReq |=>
    dispatchVector == 8'h08 && errorCodePush && errorCode == 32'h0)
    else $error("double fault wrong");
  divide_fault_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && divideError && !doubleFaultReq && !machineCheck |=>
    dispatchVector == 8'h00 && !errorCodePush && eventClass == 2'(IVD_FAULT))
    else $error("divide error wrong");
  opcode_fault_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && invalidOpcode && !doubleFaultReq && !machineCheck && !divideError |=>
    dispatchVector == 8'h06 && !errorCodePush)
    else $error("invalid opcode wrong");
  nodev_fault_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && deviceNotAvailable && !doubleFaultReq && !machineCheck && !divideError && !invalidOpcode |=>
    dispatchVector == 8'h07 && !errorCodePush)
    else $error("device not available wrong");
  machine_check_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && machineCheck && !doubleFaultReq |=>
    dispatchVector == 8'h12 && eventClass == 2'(IVD_ABORT))
    else $error("machine check wrong");
  mask_gate_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && !interruptEnable && !excReq && !nmiPending && !swIntReq |=>
    !dispatchValid && !$rose(vectorReadReq))
    else $error("masked request dispatched");
  local_low_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && locBad && !excReq && !nmiPending && !swIntReq |=>
    illegalVector && !dispatchValid)
    else $error("low local vector accepted");
  resume_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    state == IVD_RUN && handlerDone && eventClass != 2'(IVD_ABORT) |=>
    resumeTask && !taskSuspended)
    else $error("no resume");
  arch_range_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle && excReq |=>
    dispatchValid && dispatchVector <= `IVD_ARCH_LAST && eventClass != 2'(IVD_MASKABLE_REQUEST_INPUT))
    else $error("exception outside architecture range");
  soft_vector_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    swGo |=>
    dispatchValid && dispatchVector == $past(swIntVector) && eventClass == 2'(IVD_MASKABLE_REQUEST_INPUT))
    else $error("software vector not taken");
  local_map_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    locGo |=>
    dispatchValid && dispatchVector == $past(locVec))
    else $error("local pin vector wrong");
endmodule // ivd_dispatch
`default_nettype wire

//--- ivd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external vector source model
// ----------------------------------------
module ivd_ctrl_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic vectorReadReq,
  input wire logic [7:0] userVector,
  input wire logic [3:0] delay,
  output logic busVectorValid,
  output logic [7:0] busVector
);
  logic [3:0] count;
  // released bus toggles so a stale vector is never mistaken for a fresh one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= 4'h0;
      busVectorValid <= 1'b0;
      busVector <= 8'h00;
    end else if (!vectorReadReq) begin
      count <= 4'h0;
      busVectorValid <= 1'b0;
      busVector <= ~busVector;
    end else if (count == delay) begin
      busVectorValid <= 1'b1;
      busVector <= userVector;
    end else begin
      count <= count + 4'h1;
      busVector <= ~busVector;
    end
  end
endmodule // ivd_ctrl_model
`default_nettype wire

//--- test_interrupt_vector_dispatch.sv
`timescale 1ns/1ps
`include "ivd_params.svh"
`default_nettype none
module test_interrupt_vector_dispatch;
  logic clock, rst_n, ue, ie, sw, done, bv, rrq, dv, push, susp, res, ill;
  logic [1:0] pins, cls;
  logic [7:0] t0, t1, swv, uv, bvec, vec;
  logic [5:0] exc;
  logic [31:0] base, addr, ecode;
  int fails = 0, comparisons = 0, cycles = 0;
  ivd_dispatch dut (.clock(clock), .rst_n(rst_n), .localInterruptPins(pins), .localUnitEnable(ue),
    .localVectorTable0(t0), .localVectorTable1(t1), .interruptEnable(ie), .busVectorValid(bv),
    .busVector(bvec), .swIntReq(sw), .swIntVector(swv), .divideError(exc[0]), .invalidOpcode(exc[1]),
    .deviceNotAvailable(exc[2]), .doubleFaultReq(exc[3]), .hwError(exc[4]), .busError(exc[5]),
    .handlerDone(done), .descBase(base), .vectorReadReq(rrq), .dispatchValid(dv), .dispatchVector(vec),
    .descAddress(addr), .eventClass(cls), .errorCodePush(push), .errorCode(ecode),
    .taskSuspended(susp), .resumeTask(res), .illegalVector(ill));
  ivd_ctrl_model partner (.clock(clock), .rst_n(rst_n), .vectorReadReq(rrq), .userVector(uv),
    .delay(4'h3), .busVectorValid(bv), .busVector(bvec));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // waits for one dispatch, then finishes its handler; class x means not checked
  task automatic serve(input logic [7:0] v, input logic [1:0] c, input logic abort);
    int n;
    n = 0;
    while (dv !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk("valid", dv, 1);
    chk("vector", vec, v);
    if (c !== 2'bxx) chk("class", cls, c);
    chk("address", addr, base + {v, 3'b000});
    chk("push", push, v == `IVD_VEC_DOUBLE);
    if (push === 1'b1) chk("code", ecode, 0);
    chk("suspended", susp, 1);
    exc = '0; sw = 0; pins = 2'b00;
    // handler busy until the cleared pins have passed the synchronisers
    repeat (4) @(negedge clock);
    done = 1;
    @(negedge clock) done = 0;
    chk("resume", res, !abort);
    chk("released", susp, 0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_exceptions();
    logic [7:0] vs [6] = '{`IVD_VEC_DIVIDE, `IVD_VEC_INVALID_OP, `IVD_VEC_NO_DEVICE, `IVD_VEC_DOUBLE,
      `IVD_VEC_MACHINE, `IVD_VEC_MACHINE};
    logic [1:0] cs [6] = '{2'd0, 2'd0, 2'd0, 2'd2, 2'd2, 2'd2};
    for (int i = 0; i < 6; i++) begin
      exc[i] = 1;
      serve(vs[i], cs[i], i > 2);
    end
    exc = 6'b000011; // divide beats opcode
    serve(`IVD_VEC_DIVIDE, 2'd0, 0);
    $display("test exceptions done");
  endtask
  task automatic t_pins();
    ie = 1; uv = 8'h40; pins = 2'b11; // nmi first
    serve(`IVD_VEC_NMI, 2'd3, 0);
    pins = 2'b01;
    serve(8'h40, 2'd3, 0);
    ie = 0; pins = 2'b01; swv = 8'h23; repeat (12) @(negedge clock);
    chk("masked", rrq, 0);
    sw = 1;
    serve(8'h23, 2'd3, 0);
    $display("test pins done");
  endtask
  task automatic t_local();
    int n;
    ue = 1; ie = 1; t0 = 8'h05; pins = 2'b01; n = 0;
    while (ill !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("illegal", ill, 1);
    t0 = 8'h30;
    serve(8'h30, 2'd3, 0);
    t1 = 8'h3A;
    pins = 2'b10;
    serve(8'h3A, 2'd3, 0);
    ue = 0;
    $display("test local done");
  endtask
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    rst_n = 0; pins = 0; ue = 0; ie = 0; sw = 0; done = 0; exc = 0;
    t0 = 8'h30; t1 = 8'h31; swv = 8'h20; uv = 8'h40; base = 32'h0000_1000;
    repeat (3) @(negedge clock);
    rst_n = 1;
    repeat (5) @(negedge clock);
    t_exceptions();
    t_pins();
    t_local();
    final_report();
  end
endmodule // test_interrupt_vector_dispatch
`default_nettype wire
